// ### rtl/eips_line_mux.sv
// One interrupt line source picker: a port code chooses one pin out of six.
// Assumes pins are already synchronised to the clock.
`timescale 1ns/10ps
module eips_line_mux
  import eips_pkg::*;
(
  // Selection
  input  wire logic [CODE_W-1:0]    code,
  input  wire logic [NUM_PORTS-1:0] pins,
  // Chosen level
  output logic                      line
);

  always_comb begin
    line = 1'b0;
    // Unassigned codes leave the line low, so no spurious edge appears
    if (code < eips_code_t'(NUM_PORTS)) begin
      line = pins[code];
    end
  end

endmodule : eips_line_mux

// ### rtl/eips_select_low.sv
// Select register and routing for external interrupt lines 2 to 7.
// Assumes port pins arrive asynchronously and a classic Wishbone master on the clock.
`timescale 1ns/10ps
module eips_select_low
  import eips_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // Register bus
  input  wire eips_wb_req_t             wb_req,
  output eips_wb_rsp_t                  wb_rsp,
  // Port pin n of ports A..F, bit p is port p
  input  wire logic [NUM_LINES-1:0][NUM_PORTS-1:0] port_pins,
  // Routed lines, bit 0 is line 2
  output logic      [NUM_LINES-1:0]     irq_lines
);

  // ****************************************************************
  // Register and bus slave
  // ****************************************************************
  logic [NUM_LINES-1:0][CODE_W-1:0] choice_r;
  logic [NUM_LINES-1:0][CODE_W-1:0] choice_nxt;
  logic                             ack_r;
  logic                             ack_nxt;
  logic [31:0]                      rdat_r;
  logic [31:0]                      rdat_nxt;
  logic                             hit;
  logic                             req;
  logic [31:0]                      word;

  assign req = wb_req.cyc & wb_req.stb & ~ack_r;
  assign hit = (wb_req.adr == SELECT_LOW_OFFSET);

  always_comb begin
    word = READ_ZERO;
    for (int i = 0; i < NUM_LINES; i++) begin
      word[LINE2_LSB + FIELD_PITCH*i +: CODE_W] = choice_r[i];
    end
  end

  // Reserved bits are dropped on write and read as zero
  // Fields update at the taking edge as ack rises; the routed lines follow one cycle later
  always_comb begin
    choice_nxt = choice_r;
    ack_nxt    = req;
    rdat_nxt   = READ_ZERO;
    if (req && hit) begin
      rdat_nxt = word;
      if (wb_req.we) begin
        for (int i = 0; i < NUM_LINES; i++) begin
          // Each field sits in one byte lane
          if (wb_req.sel[(LINE2_LSB + FIELD_PITCH*i) / 8]) begin
            choice_nxt[i] = wb_req.dat[LINE2_LSB + FIELD_PITCH*i +: CODE_W];
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        choice_r[i] <= FIELD_RESET;
      end
      ack_r  <= 1'b0;
      rdat_r <= READ_ZERO;
    end else begin
      choice_r <= choice_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

  // ****************************************************************
  // Pin synchronisers and routing
  // ****************************************************************
  // Two stages; mux looks only at the second
  // Output flop costs a cycle but keeps the lines free of mux glitches
  logic [NUM_LINES-1:0][NUM_PORTS-1:0] sync1_r;
  logic [NUM_LINES-1:0][NUM_PORTS-1:0] sync2_r;
  logic [NUM_LINES-1:0]                line_nxt;
  logic [NUM_LINES-1:0]                line_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      line_r  <= '0;
    end else begin
      sync1_r <= port_pins;
      sync2_r <= sync1_r;
      line_r  <= line_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      eips_line_mux u_mux (
        .code (choice_r[g]),
        .pins (sync2_r[g]),
        .line (line_nxt[g])
      );
    end
  endgenerate

  assign irq_lines = line_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_LINE6_ROUTE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[4] == FOURTH_PORT_CODE) |=> (line_r[4] == $past(sync2_r[4][3])))
    else $error("line 6 not taken from port D");

  AST_RESET_ZERO: assert property (@(posedge clock)
    $fell(reset) |-> (choice_r == {NUM_LINES{FIELD_RESET}}) && (line_r == '0) && !ack_r)
    else $error("select fields not zero after reset");

  AST_LINE5_ROUTE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[3] == SECOND_PORT_CODE) |=> (line_r[3] == $past(sync2_r[3][1])))
    else $error("line 5 not taken from port B");

  AST_LINE4_ROUTE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[2] == FIFTH_PORT_CODE) |=> (line_r[2] == $past(sync2_r[2][4])))
    else $error("line 4 not taken from port E");

  AST_LINE3_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[1]) |=>
    (choice_r[1] == $past(wb_req.dat[LINE3_LSB +: CODE_W])))
    else $error("line 3 field not written");

  AST_LINE2_ROUTE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[0] == FIRST_PORT_CODE) |=> (line_r[0] == $past(sync2_r[0][0])))
    else $error("line 2 not taken from port A");

  AST_LINE7_SIXTH_PORT_CODE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[5] == SIXTH_PORT_CODE) |=> (line_r[5] == $past(sync2_r[5][5])))
    else $error("line 7 not taken from port F");

  AST_LINE7_READ: assert property (@(posedge clock) disable iff (reset)
    (req && hit && !wb_req.we) |=>
    (wb_rsp.ack && wb_rsp.dat[LINE7_LSB +: CODE_W] == $past(choice_r[5])))
    else $error("line 7 field read back wrong");

  AST_LINE2_READ: assert property (@(posedge clock) disable iff (reset)
    (req && hit && !wb_req.we) |=> (wb_rsp.dat[LINE2_LSB +: CODE_W] == $past(choice_r[0])))
    else $error("line 2 field read back wrong");

  AST_UNASSIGNED_LOW: assert property (@(posedge clock) disable iff (reset)
    (choice_r[4] > SIXTH_PORT_CODE) |=> !line_r[4])
    else $error("unassigned code left line 6 active");

  AST_LINE2_UNASSIGNED: assert property (@(posedge clock) disable iff (reset)
    (choice_r[0] > SIXTH_PORT_CODE) |=> !line_r[0])
    else $error("unassigned code left line 2 active");

  AST_LINE7_UNASSIGNED: assert property (@(posedge clock) disable iff (reset)
    (choice_r[5] > SIXTH_PORT_CODE) |=> !line_r[5])
    else $error("unassigned code left line 7 active");

  AST_LINE3_ROUTE: assert property (@(posedge clock) disable iff (reset)
    (choice_r[1] == THIRD_PORT_CODE) |=> (line_r[1] == $past(sync2_r[1][2])))
    else $error("line 3 not taken from port C");

  // Bus answer and read data
  AST_ACK_ANSWER: assert property (@(posedge clock) disable iff (reset)
    req |=> wb_rsp.ack)
    else $error("request not answered in the next cycle");

  AST_ACK_ONE_CYCLE: assert property (@(posedge clock) disable iff (reset)
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held beyond one cycle");

  AST_DAT_IDLE_ZERO: assert property (@(posedge clock) disable iff (reset)
    !wb_rsp.ack |-> (wb_rsp.dat == READ_ZERO))
    else $error("read data not zero outside ack");

  AST_RESERVED_READ_ZERO: assert property (@(posedge clock) disable iff (reset)
    wb_rsp.ack |->
    !wb_rsp.dat[LINE7_LSB + CODE_W] && !wb_rsp.dat[LINE6_LSB + CODE_W] &&
    !wb_rsp.dat[LINE5_LSB + CODE_W] && !wb_rsp.dat[LINE4_LSB + CODE_W] &&
    !wb_rsp.dat[LINE3_LSB + CODE_W] && !wb_rsp.dat[LINE2_LSB + CODE_W] &&
    (wb_rsp.dat[LINE2_LSB-1:0] == '0))
    else $error("reserved bits read back nonzero");

  AST_LINE6_READ: assert property (@(posedge clock) disable iff (reset)
    (req && hit && !wb_req.we) |=> (wb_rsp.dat[LINE6_LSB +: CODE_W] == $past(choice_r[4])))
    else $error("line 6 field read back wrong");

  // Field writes, each through the byte lane that holds it; two fields share each of lanes 1 to 3
  AST_LINE6_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[LINE6_LSB / 8]) |=>
    (choice_r[4] == $past(wb_req.dat[LINE6_LSB +: CODE_W])))
    else $error("line 6 field not written");

  AST_LINE5_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[LINE5_LSB / 8]) |=>
    (choice_r[3] == $past(wb_req.dat[LINE5_LSB +: CODE_W])))
    else $error("line 5 field not written");

  AST_LINE4_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[LINE4_LSB / 8]) |=>
    (choice_r[2] == $past(wb_req.dat[LINE4_LSB +: CODE_W])))
    else $error("line 4 field not written");

  AST_LINE2_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[LINE2_LSB / 8]) |=>
    (choice_r[0] == $past(wb_req.dat[LINE2_LSB +: CODE_W])))
    else $error("line 2 field not written");

  AST_LINE7_WRITE: assert property (@(posedge clock) disable iff (reset)
    (req && hit && wb_req.we && wb_req.sel[LINE7_LSB / 8]) |=>
    (choice_r[5] == $past(wb_req.dat[LINE7_LSB +: CODE_W])))
    else $error("line 7 field not written");

  // Fields move only on a write to this register
  AST_FIELDS_HOLD: assert property (@(posedge clock) disable iff (reset)
    !(req && hit && wb_req.we) |=> $stable(choice_r))
    else $error("select fields changed without a write");

endmodule : eips_select_low

// ### shared/eips_pkg.sv
// Constants, field layout and carrier types for the external interrupt port selector.
// Assumes one clock at 250 MHz, a synchronous active-high reset and a classic Wishbone master.
// ****************************************************************
// Overview of operation
// - Bits 26:24 pick the port feeding line 6; codes 0..5 mean ports A..F.
// - Line 6 field is read/write and resets to zero, port A.
// - Bits 22:20 pick the port feeding line 5; resets to zero.
// - Bits 18:16 pick the port feeding line 4; resets to zero.
// - Bits 14:12 pick the port feeding line 3; resets to zero.
// - Line 2 takes pin 2 of the port given by its code, A upward.
// - Line 7 code 5 takes pin 7 of port F.
// - Bits 30:28 hold the line 7 selection; resets to zero.
// - Bits 10:8 hold the line 2 selection; resets to zero.
// ****************************************************************
package eips_pkg;

  localparam int          NUM_PORTS   = 6;
  localparam int          FIRST_LINE  = 2;
  localparam int          NUM_LINES   = 6;
  localparam int          CODE_W      = 3;
  localparam int          FIELD_PITCH = 4;
  localparam int          ADDR_W      = 12;

  // Register offset, byte address of the one word
  localparam logic [ADDR_W-1:0] SELECT_LOW_OFFSET = 12'h100;

  // Field low positions, line 2 through line 7
  localparam int          LINE2_LSB = 8;
  localparam int          LINE3_LSB = 12;
  localparam int          LINE4_LSB = 16;
  localparam int          LINE5_LSB = 20;
  localparam int          LINE6_LSB = 24;
  localparam int          LINE7_LSB = 28;

  localparam logic [CODE_W-1:0] FIELD_RESET = 3'h0;
  localparam logic [31:0]       READ_ZERO   = 32'h0000_0000;

  // Port codes
  localparam logic [CODE_W-1:0] FIRST_PORT_CODE  = 3'h0;
  localparam logic [CODE_W-1:0] SECOND_PORT_CODE = 3'h1;
  localparam logic [CODE_W-1:0] THIRD_PORT_CODE  = 3'h2;
  localparam logic [CODE_W-1:0] FOURTH_PORT_CODE = 3'h3;
  localparam logic [CODE_W-1:0] FIFTH_PORT_CODE  = 3'h4;
  localparam logic [CODE_W-1:0] SIXTH_PORT_CODE  = 3'h5;

  typedef logic [CODE_W-1:0] eips_code_t;

  // Wishbone request from master
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0]       dat;
  } eips_wb_req_t;

  // Wishbone answer to master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } eips_wb_rsp_t;

endpackage : eips_pkg

// ### test/eips_pin_model.sv
// Model of the GPIO port pins that feed the interrupt port selector.
// Assumes the bench gives the wanted pin levels, changed after a rising edge.
`timescale 1ns/10ps
module eips_pin_model
  import eips_pkg::*;
(
  // Clock and wanted levels
  input  wire logic                                clock,
  input  wire logic [NUM_LINES-1:0][NUM_PORTS-1:0] want,
  // Pins seen by the selector
  output logic      [NUM_LINES-1:0][NUM_PORTS-1:0] port_pins
);
  // Pins move just after an edge, as real port inputs would
  always_ff @(posedge clock) begin
    port_pins <= want;
  end
endmodule : eips_pin_model

// ### test/eips_select_low_tb.sv
// Self-checking bench for the low interrupt port selector.
// Assumes the selector, the pin model and the shared package are compiled first.
`timescale 1ns/10ps
module eips_select_low_tb
  import eips_pkg::*;
;
  logic                                clock = 1'b0;
  logic                                reset = 1'b1;
  eips_wb_req_t                        wb_req = '0;
  eips_wb_rsp_t                        wb_rsp;
  logic [NUM_LINES-1:0][NUM_PORTS-1:0] want = '0;
  logic [NUM_LINES-1:0][NUM_PORTS-1:0] port_pins;
  logic [NUM_LINES-1:0]                irq_lines;
  logic [31:0]                         rd;
  int                                  n_errors = 0;
  int                                  check_count = 0;
  int                                  cycles = 0;

  always #2 clock = ~clock;

  eips_pin_model pins (.clock(clock), .want(want), .port_pins(port_pins));
  eips_select_low dut (.clock(clock), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
                       .port_pins(port_pins), .irq_lines(irq_lines));

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Classic single cycle; waits for ack, only the bench timeout ends a hang
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
    do begin
      @(posedge clock);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clock);
  endtask : bus

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check("lines after reset", 32'h0000_0000, 32'(irq_lines));
    bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
    check("reset word", 32'h0000_0000, rd);
    want <= {NUM_LINES{6'h01}};
    repeat (5) @(posedge clock);
    check("port A lines", 32'h0000_003f, 32'(irq_lines));
  endtask : t_reset

  // Each line gets a different code per pass; all eight codes visit every line
  task automatic t_codes();
    logic [31:0]                         v;
    logic [5:0]                          e;
    logic [NUM_LINES-1:0][NUM_PORTS-1:0] w;
    int                                  code;
    for (int c = 0; c < 8; c++) begin
      v = '0;
      for (int k = 0; k < NUM_LINES; k++) begin
        code = (c + k) % 8;
        v[LINE2_LSB + 4 * k +: 3] = 3'(code);
        w[k] = (code < 6) ? 6'(1 << code) : 6'h3f;
        e[k] = (code < 6);
      end
      want <= w;
      bus(1'b1, SELECT_LOW_OFFSET, v, 4'hf);
      bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
      check("word", v, rd);
      repeat (5) @(posedge clock);
      check("lines", 32'(e), 32'(irq_lines));
    end
  endtask : t_codes

  // Every field at an unassigned code, reserved bits kept zero
  task automatic t_reserved();
    want <= '1;
    bus(1'b1, SELECT_LOW_OFFSET, 32'h7777_7700, 4'hf);
    bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
    check("reserved", 32'h7777_7700, rd);
    repeat (5) @(posedge clock);
    check("unassigned lines", 32'h0000_0000, 32'(irq_lines));
    bus(1'b1, 12'h104, 32'h0000_0000, 4'hf);
    bus(1'b0, 12'h104, 32'h0000_0000, 4'hf);
    check("unmapped", 32'h0000_0000, rd);
    bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
    check("after unmapped write", 32'h7777_7700, rd);
    bus(1'b1, SELECT_LOW_OFFSET, 32'h0000_0000, 4'h2);
    bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
    check("byte lane", 32'h7777_0000, rd);
    repeat (5) @(posedge clock);
    check("byte lane lines", 32'h0000_0003, 32'(irq_lines));
  endtask : t_reserved

  // Reset in mid-run must bring every field back to port A
  task automatic t_rereset();
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check("lines in second reset", 32'h0000_0000, 32'(irq_lines));
    bus(1'b0, SELECT_LOW_OFFSET, 32'h0000_0000, 4'hf);
    check("word after second reset", 32'h0000_0000, rd);
    repeat (5) @(posedge clock);
    check("port A after second reset", 32'h0000_003f, 32'(irq_lines));
  endtask : t_rereset

  // Cut a hang short; the tests need under 150 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_codes();
    t_reserved();
    t_rereset();
    finish_test();
  end
endmodule : eips_select_low_tb
